// file: tcf_frame_builder.sv
// Purpose: parse host command frames and form the tag read address
// Assumes: one received byte per pclk cycle with rx_valid high, APB register access
// Notes: prdata and pready are registered, so each access needs no wait state
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "tcf_regs.svh"

module tcf_frame_builder (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host byte stream
    input wire logic rx_valid,
    input wire tcf_pkg::tcf_byte_t rx_data,
    // frame results
    output logic frame_done,
    output logic frame_ok,
    output tcf_pkg::tcf_byte_t read_addr
);
    import tcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    tcf_state_e state_q;
    tcf_state_e state_d;
    logic [7:0] rem_q;
    logic [7:0] lrc_q;
    logic [7:0] cmd1_q;
    logic [7:0] cmd2_q;
    logic [7:0] chg_ms_q;
    logic [7:0] prg_ms_q;
    logic [7:0] cnt_q;
    logic [7:0] seen_q;
    logic [7:0] waddr_q;
    logic [31:0] ctrl_q;
    logic done_q;
    logic ok_q;
    logic chkerr_q;
    logic cnterr_q;
    logic pulse_q;
    logic [7:0] raddr_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // byte acceptance and next state
    wire logic take = rx_valid & ctrl_q[`TCF_CTRL_EN];
    wire logic last = (rem_q == 8'h01);
    // RQ14 second command field follows
    wire logic two_cmd = (rx_data == `TCF_CMD_TWOFLD);
    // RQ12 programming burst present
    wire logic has_prg = cmd1_q[`TCF_CMD_PRGBIT];
    // RQ10 xor check compare
    wire logic chk_good = (lrc_q == rx_data);
    wire logic cnt_good = (seen_q == cnt_q);
    wire logic end_frame = take & (state_q == TCF_S_CHK);
    // RQ4 frame carried a write address
    wire logic has_wa = (seen_q != 8'h00);

    // next state after a taken byte
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TCF_S_START: state_d = (rx_data == `TCF_START_MARK) ? TCF_S_LEN : TCF_S_START;
            TCF_S_LEN: state_d = (rx_data == 8'h00) ? TCF_S_CHK : TCF_S_CMD1;
            TCF_S_CMD1: state_d = last ? TCF_S_CHK : (two_cmd ? TCF_S_CMD2 : TCF_S_CHG);
            TCF_S_CMD2: state_d = last ? TCF_S_CHK : TCF_S_CHG;
            TCF_S_CHG: state_d = last ? TCF_S_CHK : (has_prg ? TCF_S_PRG : TCF_S_CNT);
            TCF_S_PRG: state_d = last ? TCF_S_CHK : TCF_S_CNT;
            TCF_S_CNT: state_d = last ? TCF_S_CHK : TCF_S_DATA;
            TCF_S_DATA: state_d = last ? TCF_S_CHK : TCF_S_DATA;
            TCF_S_CHK: state_d = TCF_S_START;
            default: state_d = TCF_S_START;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame parser
    // RQ8 start mark then length count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= TCF_S_START;
            rem_q <= 8'h00;
        end else if (take) begin
            state_q <= state_d;
            rem_q <= (state_q == TCF_S_LEN) ? rx_data : rem_q - 8'h01;
        end
    end

    // RQ9 check covers all but start mark
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lrc_q <= 8'h00;
        end else if (take) begin
            if (state_q == TCF_S_START) begin
                lrc_q <= 8'h00;
            end else if (state_q != TCF_S_CHK) begin
                lrc_q <= lrc_q ^ rx_data;
            end
        end
    end

    // captured command and data fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd1_q <= 8'h00;
            cmd2_q <= 8'h00;
            chg_ms_q <= 8'h00;
            prg_ms_q <= 8'h00;
            cnt_q <= 8'h00;
            seen_q <= 8'h00;
            waddr_q <= 8'h00;
        end else if (take) begin
            unique case (state_q)
                // RQ13 command field captured
                TCF_S_CMD1: begin
                    cmd1_q <= rx_data;
                    cmd2_q <= 8'h00;
                    prg_ms_q <= 8'h00;
                    cnt_q <= 8'h00;
                    seen_q <= 8'h00;
                end
                // RQ15 second command field
                TCF_S_CMD2: cmd2_q <= rx_data;
                // RQ11 charge-up milliseconds
                TCF_S_CHG: chg_ms_q <= rx_data;
                TCF_S_PRG: prg_ms_q <= rx_data;
                // RQ16 announced field count
                TCF_S_CNT: cnt_q <= rx_data;
                TCF_S_DATA: begin
                    seen_q <= seen_q + 8'h01;
                    if (seen_q == 8'h00) begin
                        waddr_q <= rx_data;
                    end
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame results and status; hardware set wins over software clear
    wire logic clr = pready_q & psel & penable & pwrite & (paddr == `TCF_OFF_CTRL)
                     & pwdata[`TCF_CTRL_CLR];
    wire logic good = chk_good & cnt_good;
    // RQ4 executed function and page
    wire logic [7:0] raddr_d = {waddr_q[`TCF_WA_FUNC_HI:`TCF_WA_FUNC_LO],
                                waddr_q[`TCF_WA_PAGE_HI:`TCF_WA_PAGE_LO]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            ok_q <= 1'b0;
            chkerr_q <= 1'b0;
            cnterr_q <= 1'b0;
        end else begin
            done_q <= end_frame | (done_q & ~clr);
            ok_q <= end_frame ? good : (ok_q & ~clr);
            chkerr_q <= (end_frame & ~chk_good) | (chkerr_q & ~clr);
            cnterr_q <= (end_frame & ~cnt_good) | (cnterr_q & ~clr);
        end
    end

    // RQ3 read address status and page
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q <= 1'b0;
            raddr_q <= 8'h00;
        end else begin
            pulse_q <= end_frame;
            if (end_frame & good & has_wa) begin
                raddr_q <= raddr_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; data and answer are prepared in the setup cycle
    wire logic setup = psel & ~penable;
    wire logic wr_ctrl = pready_q & psel & penable & pwrite & (paddr == `TCF_OFF_CTRL);
    wire logic mapped = (paddr == `TCF_OFF_CTRL) | (paddr == `TCF_OFF_STATUS)
                        | (paddr == `TCF_OFF_CMD) | (paddr == `TCF_OFF_BURST)
                        | (paddr == `TCF_OFF_COUNT) | (paddr == `TCF_OFF_ADDR);
    wire logic checkw = (cmd2_q == `TCF_CMD2_SYNC);
    wire logic [31:0] status_w = {27'h0, checkw, cnterr_q, chkerr_q, ok_q, done_q};
    wire logic [31:0] rdata_w =
        (paddr == `TCF_OFF_CTRL) ? {31'h0, ctrl_q[`TCF_CTRL_EN]} :
        (paddr == `TCF_OFF_STATUS) ? status_w :
        (paddr == `TCF_OFF_CMD) ? {16'h0, cmd2_q, cmd1_q} :
        (paddr == `TCF_OFF_BURST) ? {16'h0, prg_ms_q, chg_ms_q} :
        (paddr == `TCF_OFF_COUNT) ? {16'h0, seen_q, cnt_q} :
        (paddr == `TCF_OFF_ADDR) ? {16'h0, raddr_q, waddr_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= (setup & ~pwrite) ? rdata_w : 32'h0;
        end
    end

    // control register, enable bit only is stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TCF_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= {31'h0, pwdata[`TCF_CTRL_EN]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign frame_done = pulse_q;
    assign frame_ok = ok_q;
    assign read_addr = raddr_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start;
        take && state_q == TCF_S_START && rx_data == `TCF_START_MARK;
    endsequence

    sequence s_len;
        take && state_q == TCF_S_LEN;
    endsequence

    // start, length and check byte path
    chk_start_then_len: assert property (s_start |=> state_q == TCF_S_LEN) // RQ8
        else $error("start mark did not lead to length");
    chk_start_drop: assert property (take && state_q == TCF_S_START // RQ8
                                     && rx_data != `TCF_START_MARK |=> state_q == TCF_S_START)
        else $error("stray byte left start state");
    chk_len_loads_rem: assert property (s_len ##0 (rx_data != 8'h00) // RQ8
                                        |=> rem_q == $past(rx_data))
        else $error("length not loaded");
    chk_lrc_restart: assert property (s_start ##1 (state_q == TCF_S_LEN) |-> lrc_q == 8'h00) // RQ9
        else $error("check sum not cleared at start");
    chk_lrc_xor: assert property (take && state_q inside {TCF_S_LEN, TCF_S_DATA} // RQ10
                                  |=> lrc_q == ($past(lrc_q) ^ $past(rx_data)))
        else $error("check sum not xor");
    chk_bad_check: assert property (end_frame && !chk_good |=> chkerr_q && !ok_q) // RQ10
        else $error("bad check byte accepted");
    chk_done_pulse: assert property (end_frame |=> frame_done ##1 !frame_done) // RQ9
        else $error("frame end pulse wrong");

    // command and field capture
    chk_charge_ms: assert property (take && state_q == TCF_S_CHG // RQ11
                                    |=> chg_ms_q == $past(rx_data))
        else $error("charge-up duration not captured");
    chk_prog_path: assert property (take && state_q == TCF_S_CHG && !last && has_prg // RQ12
                                    |=> state_q == TCF_S_PRG)
        else $error("programming burst field skipped");
    chk_prog_skip: assert property (take && state_q == TCF_S_CHG && !last && !has_prg // RQ12
                                    |=> state_q == TCF_S_CNT)
        else $error("programming burst field expected wrongly");
    chk_read_only: assert property (take && state_q == TCF_S_CMD1 // RQ13
                                    && rx_data == `TCF_CMD_READ && !last |=> state_q == TCF_S_CHG)
        else $error("read command path wrong");
    chk_two_cmd: assert property (take && state_q == TCF_S_CMD1 && two_cmd && !last // RQ14
                                  |=> state_q == TCF_S_CMD2)
        else $error("second command field not expected");
    chk_sync_flag: assert property (take && state_q == TCF_S_CMD2 // RQ15
                                    |=> cmd2_q == $past(rx_data))
        else $error("second command field not captured");
    chk_count_load: assert property (take && state_q == TCF_S_CNT // RQ16
                                     |=> cnt_q == $past(rx_data))
        else $error("field count not captured");
    chk_data_count: assert property (take && state_q == TCF_S_DATA // RQ16
                                     |=> seen_q == $past(seen_q) + 8'h01)
        else $error("data field not counted");
    chk_count_err: assert property (end_frame && !cnt_good |=> cnterr_q && !frame_ok) // RQ16
        else $error("field count mismatch missed");

    // read address result
    chk_read_addr: assert property (end_frame && good && has_wa // RQ3
                                    |=> read_addr == $past(raddr_d) && frame_done)
        else $error("read address wrong");
    chk_addr_hold: assert property (!(end_frame && good && has_wa) // RQ3
                                    |=> $stable(read_addr))
        else $error("read address changed without a good frame");
    chk_exec_func: assert property (frame_done && frame_ok && has_wa // RQ4
                                    |-> read_addr[7:6] == waddr_q[1:0]
                                        && read_addr[5:0] == waddr_q[7:2])
        else $error("read address does not report function and page");

endmodule // tcf_frame_builder

// file: tcf_regs.svh
// Purpose: register offsets, field positions, reset values and frame codes
// Assumes: 32-bit APB data, one aligned word per register
// Notes: the block list below summarises the frame handling
//
// What the document requires of this block and its host
// RQ1: write address upper six bits hold page
// RQ2: write address low two bits select function
// RQ3: read address is status plus page fields
// RQ4: read address reports executed function and page
// RQ5: reserved status data is not identification
// RQ6: host compares read address with request
// RQ7: host resends after not-reliable response
// RQ8: frame starts 01, then length byte
// RQ9: check byte covers all but start mark
// RQ10: check byte is xor of covered bytes
// RQ11: first data field is charge-up milliseconds
// RQ12: programming commands carry programming burst milliseconds
// RQ13: command 08 reads with charge-up only
// RQ14: command E8 adds second command field
// RQ15: second command 06 requests data check word
// RQ16: count byte gives number of fields following
// RQ17: host sends keyword, password, data, write frame
// RQ18: host waits for response before next frame
`ifndef TCF_REGS_SVH
`define TCF_REGS_SVH

// register byte offsets
`define TCF_OFF_CTRL 12'h000
`define TCF_OFF_STATUS 12'h004
`define TCF_OFF_CMD 12'h008
`define TCF_OFF_BURST 12'h00c
`define TCF_OFF_COUNT 12'h010
`define TCF_OFF_ADDR 12'h014

// control fields
`define TCF_CTRL_EN 0
`define TCF_CTRL_CLR 1
`define TCF_CTRL_RST 32'h0000_0001

// status fields
`define TCF_ST_DONE 0
`define TCF_ST_OK 1
`define TCF_ST_CHKERR 2
`define TCF_ST_CNTERR 3
`define TCF_ST_CHECKW 4

// frame codes
`define TCF_START_MARK 8'h01
`define TCF_CMD_READ 8'h08
`define TCF_CMD_TWOFLD 8'he8
`define TCF_CMD2_SYNC 8'h06
`define TCF_CMD_PRGBIT 5

// write address layout, sliced to build the read address
`define TCF_WA_PAGE_HI 7
`define TCF_WA_PAGE_LO 2
`define TCF_WA_FUNC_HI 1
`define TCF_WA_FUNC_LO 0

`endif

// file: tcf_pkg.sv
// Purpose: shared types of the tag command frame builder
// Assumes: nothing beyond the constants header
// Notes: parser states walk one received byte at a time
package tcf_pkg;

    // frame parser states
    typedef enum logic [3:0] {
        TCF_S_START = 4'b0000,
        TCF_S_LEN = 4'b0001,
        TCF_S_CMD1 = 4'b0010,
        TCF_S_CMD2 = 4'b0011,
        TCF_S_CHG = 4'b0100,
        TCF_S_PRG = 4'b0101,
        TCF_S_CNT = 4'b0110,
        TCF_S_DATA = 4'b0111,
        TCF_S_CHK = 4'b1000
    } tcf_state_e;

    // page functions carried in write and read addresses
    typedef enum logic [1:0] {
        TCF_F_READ = 2'b00,
        TCF_F_PROG = 2'b01,
        TCF_F_LOCK = 2'b10,
        TCF_F_SELRD = 2'b11
    } tcf_func_e;

    typedef logic [7:0] tcf_byte_t;

endpackage

// file: tcf_host_model.sv
// Purpose: host side that streams command frames into the frame builder
// Assumes: one byte taken per pclk edge while rx_valid is high
// Notes: idle rx_data shows the inverted last byte, never a stale copy
`timescale 1ns/1ps

module tcf_host_model (
    // clock
    pclk,
    // byte stream towards the builder
    rx_valid,
    rx_data,
    // frame result from the builder
    frame_done
);
    input wire logic pclk;
    output logic rx_valid;
    output tcf_pkg::tcf_byte_t rx_data;
    input wire logic frame_done;
    import tcf_pkg::*;

    // idle stream at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // page and function
    function automatic tcf_byte_t make_wa(input logic [5:0] pg, input tcf_func_e fn);
        return {pg, fn};
    endfunction

    // one byte, then an optional idle gap
    task automatic put(input tcf_byte_t b, input int gap);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge pclk);
        if (gap > 0) begin
            rx_valid <= 1'b0;
            rx_data <= ~b;
            repeat (gap) @(posedge pclk);
        end
    endtask

    // whole frame; bad flips the check byte on purpose
    task automatic send_frame(input tcf_byte_t body[$], input bit bad, input int gap);
        tcf_byte_t chk;
        chk = tcf_byte_t'(body.size());
        put(8'h01, gap);
        put(chk, gap);
        foreach (body[i]) begin
            chk = chk ^ body[i];
            put(body[i], gap);
        end
        put(bad ? ~chk : chk, 0);
        rx_valid <= 1'b0;
        rx_data <= bad ? chk : ~chk;
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (frame_done === 1'b1) break;
        end
    endtask
endmodule // tcf_host_model

// file: tb.sv
// Purpose: self-checking bench for the tag command frame builder
// Assumes: apb master here, host byte stream from tcf_host_model
// Notes: status is cleared before every frame so each result stands alone
`timescale 1ns/1ps
`include "tcf_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb;
    import tcf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_valid, frame_done, frame_ok;
    tcf_byte_t rx_data, read_addr;
    int miscompares = 0;
    int n_tests = 0;
    int n_done = 0;
    logic [31:0] q;
    logic err;
    logic [5:0] pg [4] = '{6'h01, 6'h02, 6'h10, 6'h11};
    tcf_byte_t wa;

    ////////////////////////////////////////////////////////////////////////////
    // clock and done pulse counter
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (frame_done === 1'b1) n_done++;

    tcf_frame_builder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .frame_done(frame_done),
        .frame_ok(frame_ok), .read_addr(read_addr));
    tcf_host_model host (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .frame_done(frame_done));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
        input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, q & m)
    endtask

    // clear status, send a frame, check done count, status and frame_ok
    task automatic frame(input tcf_byte_t body[$], input bit bad, input int gap,
        input bit en, input logic [4:0] st);
        int d0;
        apb(1'b1, `TCF_OFF_CTRL, {30'h0, 1'b1, en});
        d0 = n_done;
        host.send_frame(body, bad, gap);
        @(posedge pclk);
        `CHK("frame_done", d0 + int'(en), n_done)
        `CHK("frame_ok", st[1], frame_ok)
        rd_chk(`TCF_OFF_STATUS, 32'h1f, {27'h0, st}, "status");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`TCF_OFF_CTRL, 32'hffffffff, 32'h1, "ctrl reset");
        rd_chk(`TCF_OFF_STATUS, 32'hffffffff, 32'h0, "status reset");
        frame('{8'h08, 8'h32}, 1'b0, 0, 1'b1, 5'h03);
        rd_chk(`TCF_OFF_BURST, 32'hff, 32'h32, "charge ms");
        rd_chk(`TCF_OFF_CTRL, 32'hffffffff, 32'h1, "ctrl clear self");
        frame('{8'h08, 8'h32}, 1'b1, 1, 1'b1, 5'h05);
        frame('{8'h08, 8'h32}, 1'b0, 2, 1'b1, 5'h03);
        frame('{8'he8, 8'h06, 8'h32, 8'h0f, 8'h0c, 8'hbb, 8'heb, 8'h01, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03}, 1'b0, 0, 1'b1, 5'h13);
        rd_chk(`TCF_OFF_CMD, 32'hffff, 32'h06e8, "cmd fields");
        rd_chk(`TCF_OFF_BURST, 32'hffff, 32'h0f32, "burst ms");
        rd_chk(`TCF_OFF_COUNT, 32'hffff, 32'h0c0c, "count");
        for (int f = 0; f < 4; f++) begin
            wa = host.make_wa(pg[f], tcf_func_e'(f));
            frame('{8'h48, 8'h32, 8'h01, wa}, 1'b0, 1, 1'b1, 5'h03);
            `CHK("read_addr", {f[1:0], pg[f]}, read_addr)
            rd_chk(`TCF_OFF_ADDR, 32'hffff, {16'h0, f[1:0], pg[f], wa}, "addr");
        end
        frame('{8'h6c, 8'h32, 8'h07, 8'h01, 8'h0a}, 1'b0, 0, 1'b1, 5'h03);
        rd_chk(`TCF_OFF_BURST, 32'hffff, 32'h0732, "lock burst");
        `CHK("read_addr", 8'h82, read_addr)
        frame('{8'h48, 8'h32, 8'h02, 8'h08}, 1'b0, 0, 1'b1, 5'h09);
        rd_chk(`TCF_OFF_COUNT, 32'hffff, 32'h0102, "count err");
        `CHK("read_addr", 8'h82, read_addr)
        host.put(8'h55, 1);
        host.put(8'h7e, 1);
        frame('{8'h08, 8'h32}, 1'b0, 0, 1'b1, 5'h03);
        `CHK("read_addr", 8'h82, read_addr)
        frame('{8'h08, 8'h32}, 1'b0, 0, 1'b0, 5'h00);
        rd_chk(`TCF_OFF_CTRL, 32'hffffffff, 32'h0, "ctrl off");
        apb(1'b1, `TCF_OFF_CTRL, 32'h1);
        rd_chk(12'h018, 32'hffffffff, 32'h0, "unmapped data");
        `CHK("unmapped err", 1'b1, err)
        test_done();
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        test_done();
    end
endmodule // tb
